// ### rtl/gpp_consts.svh
// Function
// - up to eight pins, one bit each
// - inputs synchronised, frozen when input disabled
// - pin value readable in either direction
// - reset: drivers off, inputs enabled
// - pin n config at register index 0x10 plus n
// - enable write and set port
// - level set and clear ports
// - level flip or input write inverts level
// - enable clear and flip ports
// - invert bit flips input and output, not a peripheral override output
// - invert change gives a visible edge
// - pull-high bit turns on pull-up
// - sense change may drop or defer events
// - wake rules per sense and pin kind
// - alias registers act like regular ones
// - peripheral override per pin
// - flag sets, request holds until cleared
// - one-cycle pulse minimum
// - three-cycle dead time after event, none on fully asynchronous pins
// - event output per pin, no inputs
// - config kept in sleep, sync needs clock
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
// register indices, byte address is four times the index
`define GPP_IX_DIR    6'h00
`define GPP_IX_DSET   6'h01
`define GPP_IX_DCLR   6'h02
`define GPP_IX_DFLIP  6'h03
`define GPP_IX_OUT    6'h04
`define GPP_IX_OSET   6'h05
`define GPP_IX_OCLR   6'h06
`define GPP_IX_OFLIP  6'h07
`define GPP_IX_IN     6'h08
`define GPP_IX_FLAGS  6'h09
`define GPP_IX_PCTRL  6'h0a
`define GPP_IX_CFG0   6'h10
`define GPP_IX_ADIR   6'h20
`define GPP_IX_AOUT   6'h21
`define GPP_IX_AIN    6'h22
`define GPP_IX_AFLAGS 6'h23
`define GPP_CFG_INV   7
`define GPP_CFG_PULL  3
`define GPP_DEAD_CYC  2'h3
`define GPP_RESP_OK   2'h0
`define GPP_RESP_ERR  2'h2
`endif

// ### rtl/gpp_pkg.sv
package gpp_pkg;
   typedef enum logic [2:0] {
      GPP_SNS_NONE = 3'b000,
      GPP_SNS_ANY  = 3'b001,
      GPP_SNS_RISE = 3'b010,
      GPP_SNS_FALL = 3'b011,
      GPP_SNS_OFF  = 3'b100,
      GPP_SNS_LOW  = 3'b101
   } gpp_sense_t;
   typedef struct packed {
      logic       inv;
      logic       pull;
      logic [2:0] sense;
   } gpp_pcfg_t;
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } gpp_axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } gpp_axi_rsp_t;
   typedef struct packed {
      logic [7:0] en;
      logic [7:0] oe;
      logic [7:0] out;
   } gpp_ovr_t;
   typedef struct packed {
      logic [7:0] oe;
      logic [7:0] out;
      logic [7:0] pull;
      logic [7:0] ev;
   } gpp_pin_o_t;
   typedef struct packed {
      logic [7:0]            dir;
      logic [7:0]            out;
      logic [7:0]            flags;
      logic [7:0]            sync1;
      logic [7:0]            sync2;
      logic [7:0]            prev;
      gpp_pcfg_t [7:0]       cfg;
      logic [7:0][1:0]       dead;
      logic                  slew;
      logic                  aw_got;
      logic                  w_got;
      logic [7:0]            awaddr;
      logic [7:0]            wdata;
      logic                  wen;
      logic                  awrdy;
      logic                  wrdy;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arrdy;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [7:0]            rdata;
      gpp_pin_o_t            pin;
      logic                  irq;
      logic                  wake;
   } gpp_state_t;
endpackage

// ### rtl/gpp_port.sv
`timescale 1ns/1ps
`include "gpp_consts.svh"
module gpp_port #(
   parameter int         NPINS      = 8,
   parameter logic [7:0] ASYNC_MASK = 8'h00
) (
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   input  wire gpp_pkg::gpp_axi_req_t rq,
   output gpp_pkg::gpp_axi_rsp_t      rsp,
   input  wire logic [7:0]            pin_in,
   input  wire gpp_pkg::gpp_ovr_t     ovr,
   output gpp_pkg::gpp_pin_o_t        pin_o,
   output logic                       slew_limit,
   output logic                       irq,
   output logic                       wake
);
   // ==========================================================
   // parameters
   localparam logic [7:0] PMASK = 8'((16'h1 << NPINS) - 16'h1);

   generate
      if (NPINS < 1 || NPINS > 8) begin : g_bad
         $error("NPINS must lie between 1 and 8");
      end
   endgenerate

   gpp_pkg::gpp_state_t st;
   gpp_pkg::gpp_state_t n;
   logic [7:0]          pval;
   logic [7:0]          hit;
   logic [7:0]          in_on;
   logic [7:0]          flag_clr;
   logic [5:0]          widx;
   logic [5:0]          ridx;
   logic                do_wr;
   logic [7:0]          d8;

   // ==========================================================
   // helpers
   function automatic logic [7:0] sense_on(
      input gpp_pkg::gpp_pcfg_t [7:0] c);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         unique case (gpp_pkg::gpp_sense_t'(c[i].sense))
            gpp_pkg::GPP_SNS_ANY,
            gpp_pkg::GPP_SNS_RISE,
            gpp_pkg::GPP_SNS_FALL,
            gpp_pkg::GPP_SNS_LOW: m[i] = 1'b1;
            default:              m[i] = 1'b0;
         endcase
      end
      return m;
   endfunction

   // rising or falling only wakes on fully asynchronous pins
   function automatic logic [7:0] wake_ok(
      input gpp_pkg::gpp_pcfg_t [7:0] c);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         unique case (gpp_pkg::gpp_sense_t'(c[i].sense))
            gpp_pkg::GPP_SNS_ANY,
            gpp_pkg::GPP_SNS_LOW:  m[i] = 1'b1;
            gpp_pkg::GPP_SNS_RISE,
            gpp_pkg::GPP_SNS_FALL: m[i] = ASYNC_MASK[i];
            default:               m[i] = 1'b0;
         endcase
      end
      return m;
   endfunction

   function automatic logic [9:0] rd_word(input logic [5:0] ix);
      logic [5:0] r;
      logic [9:0] v;
      r = ix;
      v = {`GPP_RESP_OK, 8'h00};
      unique case (ix)
         `GPP_IX_ADIR:   r = `GPP_IX_DIR;
         `GPP_IX_AOUT:   r = `GPP_IX_OUT;
         `GPP_IX_AIN:    r = `GPP_IX_IN;
         `GPP_IX_AFLAGS: r = `GPP_IX_FLAGS;
         default:        r = ix;
      endcase
      if (r[5:3] == `GPP_IX_CFG0 >> 3) begin
         v[`GPP_CFG_INV]  = st.cfg[r[2:0]].inv;
         v[`GPP_CFG_PULL] = st.cfg[r[2:0]].pull;
         v[2:0]           = st.cfg[r[2:0]].sense;
      end else begin
         unique case (r)
            `GPP_IX_DIR, `GPP_IX_DSET,
            `GPP_IX_DCLR, `GPP_IX_DFLIP: v[7:0] = st.dir;
            `GPP_IX_OUT, `GPP_IX_OSET,
            `GPP_IX_OCLR, `GPP_IX_OFLIP: v[7:0] = st.out;
            `GPP_IX_IN:    v[7:0] = pval & PMASK;
            `GPP_IX_FLAGS: v[7:0] = st.flags;
            `GPP_IX_PCTRL: v[0]   = st.slew;
            default:       v[9:8] = `GPP_RESP_ERR;
         endcase
      end
      return v;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      n        = st;
      flag_clr = 8'h00;
      d8       = st.wdata & PMASK;
      widx     = st.awaddr[7:2];
      do_wr    = st.aw_got && st.w_got;
      ridx     = widx;
      pval     = st.sync2 ^ {st.cfg[7].inv, st.cfg[6].inv,
                             st.cfg[5].inv, st.cfg[4].inv,
                             st.cfg[3].inv, st.cfg[2].inv,
                             st.cfg[1].inv, st.cfg[0].inv};
      hit      = 8'h00;
      in_on    = 8'h00;

      // pin input path
      for (int i = 0; i < 8; i++) begin
         in_on[i] = (st.cfg[i].sense != 3'(gpp_pkg::GPP_SNS_OFF))
                    && PMASK[i];
         // no clock to the synchroniser while disabled; prev holds
         // too, so a change across the gap fires on re-enable
         if (in_on[i]) begin
            n.sync1[i] = pin_in[i];
            n.sync2[i] = st.sync1[i];
            n.prev[i]  = pval[i];
         end
         if (in_on[i] && (st.dead[i] == 2'h0 || ASYNC_MASK[i])) begin
            unique case (gpp_pkg::gpp_sense_t'(st.cfg[i].sense))
               gpp_pkg::GPP_SNS_ANY:  hit[i] = pval[i] ^ st.prev[i];
               gpp_pkg::GPP_SNS_RISE: hit[i] = pval[i] & ~st.prev[i];
               gpp_pkg::GPP_SNS_FALL: hit[i] = ~pval[i] & st.prev[i];
               gpp_pkg::GPP_SNS_LOW:  hit[i] = ~pval[i];
               default:               hit[i] = 1'b0;
            endcase
         end
         if (hit[i]) begin
            n.dead[i] = `GPP_DEAD_CYC;
         end else if (st.dead[i] != 2'h0) begin
            n.dead[i] = st.dead[i] - 2'h1;
         end
      end

      // bus write
      if (do_wr) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = `GPP_RESP_OK;
         unique case (widx)
            `GPP_IX_ADIR:   ridx = `GPP_IX_DIR;
            `GPP_IX_AOUT:   ridx = `GPP_IX_OUT;
            `GPP_IX_AIN:    ridx = `GPP_IX_IN;
            `GPP_IX_AFLAGS: ridx = `GPP_IX_FLAGS;
            default:        ridx = widx;
         endcase
         if (ridx[5:3] == `GPP_IX_CFG0 >> 3) begin
            if (st.wen) begin
               n.cfg[ridx[2:0]].inv   = st.wdata[`GPP_CFG_INV];
               n.cfg[ridx[2:0]].pull  = st.wdata[`GPP_CFG_PULL];
               n.cfg[ridx[2:0]].sense = st.wdata[2:0];
            end
         end else begin
            unique case (ridx)
               `GPP_IX_DIR:   if (st.wen) n.dir = d8;
               `GPP_IX_DSET:  if (st.wen) n.dir = st.dir | d8;
               `GPP_IX_DCLR:  if (st.wen) n.dir = st.dir & ~d8;
               `GPP_IX_DFLIP: if (st.wen) n.dir = st.dir ^ d8;
               `GPP_IX_OUT:   if (st.wen) n.out = d8;
               `GPP_IX_OSET:  if (st.wen) n.out = st.out | d8;
               `GPP_IX_OCLR:  if (st.wen) n.out = st.out & ~d8;
               `GPP_IX_OFLIP,
               `GPP_IX_IN:    if (st.wen) n.out = st.out ^ d8;
               `GPP_IX_FLAGS: if (st.wen) flag_clr = d8;
               `GPP_IX_PCTRL: if (st.wen) n.slew = st.wdata[0];
               default:       n.bresp = `GPP_RESP_ERR;
            endcase
         end
      end
      // a new event in the clearing cycle survives
      n.flags = ((st.flags & ~flag_clr) | hit) & PMASK;

      // write address and data channels, either order
      if (rq.awvalid && st.awrdy) begin
         n.aw_got = 1'b1;
         n.awaddr = rq.awaddr;
      end
      if (rq.wvalid && st.wrdy) begin
         n.w_got = 1'b1;
         n.wdata = rq.wdata[7:0];
         n.wen   = rq.wstrb[0];
      end
      if (st.bvalid && rq.bready) begin
         n.bvalid = 1'b0;
      end
      n.awrdy = !n.aw_got && !n.bvalid && !do_wr;
      n.wrdy  = !n.w_got && !n.bvalid && !do_wr;

      // read channel
      if (st.rvalid && rq.rready) begin
         n.rvalid = 1'b0;
      end
      if (rq.arvalid && st.arrdy) begin
         n.rvalid            = 1'b1;
         {n.rresp, n.rdata}  = rd_word(rq.araddr[7:2]);
      end
      n.arrdy = !n.rvalid;

      // pin outputs, peripheral wins where it is enabled
      for (int i = 0; i < 8; i++) begin
         if (ovr.en[i] && PMASK[i]) begin
            n.pin.oe[i]  = ovr.oe[i];
            n.pin.out[i] = ovr.out[i];
         end else begin
            n.pin.oe[i]  = n.dir[i];
            n.pin.out[i] = n.out[i] ^ n.cfg[i].inv;
         end
         n.pin.pull[i] = n.cfg[i].pull && PMASK[i];
         n.pin.ev[i]   = in_on[i] ? pval[i] : 1'b0;
      end
      n.irq  = |(n.flags & sense_on(n.cfg));
      n.wake = |(n.flags & wake_ok(n.cfg));
   end

   // ==========================================================
   // state register
   // ce low freezes every bit, synchronisers included, just as
   // a stopped main clock would
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else if (ce) begin
         st <= n;
      end
   end

   // ==========================================================
   // outputs
   assign rsp.awready = st.awrdy;
   assign rsp.wready  = st.wrdy;
   assign rsp.bvalid  = st.bvalid;
   assign rsp.bresp   = st.bresp;
   assign rsp.arready = st.arrdy;
   assign rsp.rvalid  = st.rvalid;
   assign rsp.rdata   = {24'h000000, st.rdata};
   assign rsp.rresp   = st.rresp;
   assign pin_o       = st.pin;
   assign slew_limit  = st.slew;
   assign irq         = st.irq;
   assign wake        = st.wake;

   // ==========================================================
   // assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   logic wr_idx_ok;
   assign wr_idx_ok = ce && do_wr && st.wen;

   property p_reset_idle;
      $rose(resetn) |-> pin_o.oe == 8'h00 && st.cfg == '0;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("pins not idle after reset");

   property p_dir_set;
      wr_idx_ok && widx == `GPP_IX_DSET |=>
         st.dir == ($past(st.dir) | $past(d8));
   endproperty
   a_dir_set: assert property (p_dir_set)
      else $error("enable set port wrong");

   property p_dir_clr;
      wr_idx_ok && widx == `GPP_IX_DCLR |=>
         (st.dir & $past(d8)) == 8'h00 &&
         (st.dir | $past(d8)) == ($past(st.dir) | $past(d8));
   endproperty
   a_dir_clr: assert property (p_dir_clr)
      else $error("enable clear port wrong");

   property p_out_clr;
      wr_idx_ok && widx == `GPP_IX_OCLR |=>
         st.out == ($past(st.out) & ~$past(d8));
   endproperty
   a_out_clr: assert property (p_out_clr)
      else $error("level clear port wrong");

   property p_in_flip;
      wr_idx_ok && widx == `GPP_IX_IN |=>
         st.out == ($past(st.out) ^ $past(d8));
   endproperty
   a_in_flip: assert property (p_in_flip)
      else $error("input write did not flip level");

   property p_irq_tie;
      irq == |(st.flags & sense_on(st.cfg));
   endproperty
   a_irq_tie: assert property (p_irq_tie)
      else $error("request does not follow flags");

   property p_dead;
      ce && hit[0] && !ASYNC_MASK[0] |=> !hit[0] [*3];
   endproperty
   a_dead: assert property (p_dead)
      else $error("event accepted in dead time");

   property p_ev_off;
      ce && st.cfg[0].sense == 3'(gpp_pkg::GPP_SNS_OFF) |=>
         !pin_o.ev[0] && $stable(st.sync2[0]);
   endproperty
   a_ev_off: assert property (p_ev_off)
      else $error("disabled input still active");

   property p_inv_out;
      ce && !ovr.en[0] |=>
         pin_o.out[0] == (st.out[0] ^ st.cfg[0].inv);
   endproperty
   a_inv_out: assert property (p_inv_out)
      else $error("output inversion wrong");

   property p_w1c;
      wr_idx_ok && widx == `GPP_IX_FLAGS && d8[0] && !hit[0] |=>
         !st.flags[0];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("flag not cleared by one");

   property p_set_wins;
      ce && hit[0] |=> st.flags[0];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost");

   property p_dir_flip;
      wr_idx_ok && widx == `GPP_IX_DFLIP |=>
         st.dir == ($past(st.dir) ^ $past(d8));
   endproperty
   a_dir_flip: assert property (p_dir_flip)
      else $error("enable flip port wrong");

   property p_out_set;
      wr_idx_ok && widx == `GPP_IX_OSET |=>
         st.out == ($past(st.out) | $past(d8));
   endproperty
   a_out_set: assert property (p_out_set)
      else $error("level set port wrong");

   property p_alias_dir;
      wr_idx_ok && widx == `GPP_IX_ADIR |=> st.dir == $past(d8);
   endproperty
   a_alias_dir: assert property (p_alias_dir)
      else $error("alias write differs from regular write");

   property p_ev_on;
      ce && in_on[0] |=> pin_o.ev[0] == $past(pval[0]);
   endproperty
   a_ev_on: assert property (p_ev_on)
      else $error("event output does not follow pin");

   property p_oe_dir;
      ce && !ovr.en[0] |=> pin_o.oe[0] == st.dir[0];
   endproperty
   a_oe_dir: assert property (p_oe_dir)
      else $error("drive enable does not follow register");

   c_irq:   cover property (ce && hit[0] ##1 irq);
   c_write: cover property (rsp.bvalid && rq.bready);
   c_read:  cover property (rsp.rvalid && rq.rready);
   c_ovr:   cover property (ovr.en[0] && pin_o.oe[0]);
endmodule

// ### dv/gpp_pad_model.sv
`timescale 1ns/1ps
// ==========
// pads seen from outside: device drive wins, then the bench's
// source, then the pull-up; a floating pad wanders
module gpp_pad_model (
   input  wire logic                ref_clk,
   input  wire gpp_pkg::gpp_pin_o_t pin_o,
   input  wire logic                ext_en,
   input  wire logic [7:0]          ext_val,
   output logic [7:0]               pin_in
);
   logic [7:0] flt_r = 8'h55;

   // flips each cycle so a floating pad never reads as a stable level
   always_ff @(posedge ref_clk) begin
      flt_r <= ~flt_r;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_o.oe[i]) begin
            pin_in[i] = pin_o.out[i];
         end else if (ext_en) begin
            pin_in[i] = ext_val[i];
         end else if (pin_o.pull[i]) begin
            pin_in[i] = 1'b1;
         end else begin
            pin_in[i] = flt_r[i];
         end
      end
   end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
`include "gpp_consts.svh"
module tb;
   // ==========
   // signals
   typedef struct packed {
      logic [5:0] wix;
      logic [7:0] wd;
      logic [5:0] rix;
      logic [7:0] exp;
   } gpp_row_t;
   logic                  ref_clk;
   logic                  resetn;
   logic                  ce;
   gpp_pkg::gpp_axi_req_t rq;
   gpp_pkg::gpp_axi_rsp_t rsp;
   logic [7:0]            pin_in;
   gpp_pkg::gpp_ovr_t     ovr;
   gpp_pkg::gpp_pin_o_t   pin_o;
   logic                  slew_limit;
   logic                  irq;
   logic                  wake;
   logic                  ext_en;
   logic [7:0]            ext_val;
   logic [1:0]            r;
   logic [7:0]            d;
   int                    n_errors;
   int                    n_compared;
   logic [2:0]            codes [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
   gpp_row_t              rows [12] = '{
      '{`GPP_IX_DSET, 8'h05, `GPP_IX_DIR, 8'h05},
      '{`GPP_IX_DSET, 8'h80, `GPP_IX_DIR, 8'h85},
      '{`GPP_IX_DCLR, 8'h04, `GPP_IX_DIR, 8'h81},
      '{`GPP_IX_DFLIP, 8'h03, `GPP_IX_DIR, 8'h82},
      '{`GPP_IX_DIR, 8'hf0, `GPP_IX_DIR, 8'hf0},
      '{`GPP_IX_OSET, 8'h11, `GPP_IX_OUT, 8'h11},
      '{`GPP_IX_OCLR, 8'h01, `GPP_IX_OUT, 8'h10},
      '{`GPP_IX_OFLIP, 8'h0f, `GPP_IX_OUT, 8'h1f},
      '{`GPP_IX_IN, 8'h03, `GPP_IX_OUT, 8'h1c},
      '{`GPP_IX_ADIR, 8'h0f, `GPP_IX_DIR, 8'h0f},
      '{`GPP_IX_AOUT, 8'ha5, `GPP_IX_OUT, 8'ha5},
      '{`GPP_IX_PCTRL, 8'h01, `GPP_IX_PCTRL, 8'h01}};

   gpp_port uut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .rq(rq),
      .rsp(rsp), .pin_in(pin_in), .ovr(ovr), .pin_o(pin_o),
      .slew_limit(slew_limit), .irq(irq), .wake(wake));
   gpp_pad_model pad (.ref_clk(ref_clk), .pin_o(pin_o), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ==========
   // bus and checking tasks
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // channels are released one by one as each is taken
   task automatic axw(input logic [5:0] ix, input logic [7:0] v);
      logic aw;
      logic w;
      logic b;
      aw = 1'b1;
      w = 1'b1;
      b = 1'b0;
      @(posedge ref_clk);
      rq.awvalid <= 1'b1;
      rq.awaddr <= {ix, 2'b00};
      rq.wvalid <= 1'b1;
      rq.wdata <= {24'h000000, v};
      rq.wstrb <= 4'hf;
      rq.bready <= 1'b1;
      while (!b) begin
         @(posedge ref_clk);
         if (aw && rsp.awready) begin
            aw = 1'b0;
            rq.awvalid <= 1'b0;
         end
         if (w && rsp.wready) begin
            w = 1'b0;
            rq.wvalid <= 1'b0;
         end
         if (rsp.bvalid) begin
            b = 1'b1;
            r = rsp.bresp;
            rq.bready <= 1'b0;
         end
      end
   endtask

   task automatic axr(input logic [5:0] ix);
      logic ar;
      logic b;
      ar = 1'b1;
      b = 1'b0;
      @(posedge ref_clk);
      rq.arvalid <= 1'b1;
      rq.araddr <= {ix, 2'b00};
      rq.rready <= 1'b1;
      while (!b) begin
         @(posedge ref_clk);
         if (ar && rsp.arready) begin
            ar = 1'b0;
            rq.arvalid <= 1'b0;
         end
         if (rsp.rvalid) begin
            b = 1'b1;
            d = rsp.rdata[7:0];
            r = rsp.rresp;
            rq.rready <= 1'b0;
         end
      end
   endtask

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // a full run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      close_out();
   end

   // ==========
   // tests
   initial begin
      rq = '0;
      ovr = '0;
      ce = 1'b1;
      resetn = 1'b0;
      ext_en = 1'b0;
      ext_val = 8'hff;
      n_errors = 0;
      n_compared = 0;
      repeat (10) @(posedge ref_clk);
      chk("oe_in_reset", pin_o.oe, 8'h00);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      foreach (rows[i]) begin
         axw(rows[i].wix, rows[i].wd);
         chk("bresp", r, `GPP_RESP_OK);
         axr(rows[i].rix);
         chk("reg", d, rows[i].exp);
      end
      chk("pin_oe", pin_o.oe, 8'h0f);
      chk("pin_out", pin_o.out, 8'ha5);
      chk("slew", slew_limit, 1'b1);
      $display("test table done");
      axw(6'h0b, 8'hff);
      chk("unmapped_bresp", r, `GPP_RESP_ERR);
      axr(6'h0b);
      chk("unmapped_rresp", r, `GPP_RESP_ERR);
      chk("unmapped_rdata", d, 8'h00);
      $display("test unmapped done");
      axw(`GPP_IX_DIR, 8'h00);
      ext_en <= 1'b1;
      ext_val <= 8'h5a;
      repeat (4) @(posedge ref_clk);
      axr(`GPP_IX_IN);
      chk("in_input", d, 8'h5a);
      axw(`GPP_IX_DIR, 8'hff);
      axw(`GPP_IX_OUT, 8'h3c);
      repeat (4) @(posedge ref_clk);
      axr(`GPP_IX_IN);
      chk("in_output", d, 8'h3c);
      axw(`GPP_IX_CFG0 + 6'h01, 8'h88);
      chk("inv_out", pin_o.out, 8'h3e);
      chk("pull", pin_o.pull, 8'h02);
      repeat (4) @(posedge ref_clk);
      axr(`GPP_IX_IN);
      chk("inv_in", d, 8'h3c);
      $display("test pins done");
      axw(`GPP_IX_CFG0 + 6'h01, 8'h00);
      axw(`GPP_IX_DIR, 8'h00);
      axw(`GPP_IX_CFG0, 8'h04);
      ext_val <= 8'hff;
      repeat (4) @(posedge ref_clk);
      chk("events", pin_o.ev, 8'hfe);
      $display("test events done");
      ce <= 1'b0;
      ext_val <= 8'h00;
      repeat (4) @(posedge ref_clk);
      chk("ev_frozen", pin_o.ev, 8'hfe);
      ce <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("ev_resumed", pin_o.ev, 8'h00);
      ext_val <= 8'hff;
      $display("test hold done");
      // pin 0 is not fully asynchronous, so rise and fall must not wake;
      // re-enabling it may raise a stale edge, the flag clear drops it
      for (int k = 0; k < 4; k++) begin
         axw(`GPP_IX_CFG0, {5'h00, codes[k]});
         axw(`GPP_IX_FLAGS, 8'hff);
         @(posedge ref_clk);
         ext_val[0] <= 1'b0;
         @(posedge ref_clk);
         ext_val[0] <= 1'b1;
         repeat (6) @(posedge ref_clk);
         chk("irq_set", irq, 1'b1);
         chk("wake", wake, codes[k] == 3'h1 || codes[k] == 3'h5);
         axw(`GPP_IX_FLAGS, 8'h00);
         axr(`GPP_IX_FLAGS);
         chk("flags_kept", d, 8'h01);
         axw(`GPP_IX_AFLAGS, 8'h01);
         axr(`GPP_IX_FLAGS);
         chk("flags_clr", d, 8'h00);
         chk("irq_clr", irq, 1'b0);
      end
      $display("test sense done");
      ovr <= '{en: 8'h01, oe: 8'h01, out: 8'h01};
      repeat (3) @(posedge ref_clk);
      chk("ovr_oe", pin_o.oe, 8'h01);
      chk("ovr_out", pin_o.out[0], 1'b1);
      ovr <= '0;
      $display("test override done");
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
      axr(`GPP_IX_OUT);
      chk("out_rst", d, 8'h00);
      chk("oe_rst", pin_o.oe, 8'h00);
      $display("test reset again done");
      close_out();
   end
endmodule
